/* File: hdl/peripheral_irq_flag_bank.sv */
`timescale 1ns/1ps
`include "irq_flag_cfg.svh"
module peripheral_irq_flag_bank
    import irq_flag_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] bus_addr,
    input wire irq_flag_pkg::word_t bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output irq_flag_pkg::word_t bus_rdata,
    input wire logic write_done_evt,
    input wire logic conv_done_evt,
    input wire logic timer_b_wrap_evt,
    input wire logic rx_avail,
    input wire irq_flag_pkg::byte_t rx_data,
    input wire logic tx_empty,
    input wire logic cmp_a_output,
    input wire logic cmp_b_output,
    input wire logic osc_fail,
    input wire logic por_seen,
    input wire logic brownout_reset,
    input wire logic watchdog_reset,
    input wire logic ext_reset_pin,
    output logic rx_pop,
    output logic tx_push,
    output irq_flag_pkg::byte_t tx_data,
    output logic periph_irq,
    output logic irq,
    output logic ulp_wake_en,
    output logic sw_brownout_en
);
    import irq_flag_pkg::*;

    // ==========================================================
    // address decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    wire wr_flag = bus_wr && hit(bus_addr, `FLAG_OFS);
    wire wr_enable = bus_wr && hit(bus_addr, `ENABLE_OFS);
    wire wr_ctrl = bus_wr && hit(bus_addr, `CTRL_OFS);
    wire wr_power = bus_wr && hit(bus_addr, `POWER_OFS);
    wire wr_txd = bus_wr && hit(bus_addr, `TXD_OFS);
    wire rd_rxd = bus_rd && hit(bus_addr, `RXD_OFS);

    // ==========================================================
    // state
    flags_s flags;
    flags_s next_flags;
    flags_s flag_view;
    byte_t periph_enable_reg;
    logic [1:0] ctrl;
    logic global_irq_enable;
    logic periph_irq_enable;
    byte_t sw_clear;
    byte_t read_mux;
    logic [`SYNC_WIDTH-1:0] pin_level;
    logic [`SYNC_WIDTH-1:0] pin_rise;
    logic [`SYNC_WIDTH-1:0] pin_change;

    pwr_bus_if pwr_bus ();

    // ==========================================================
    // comparators and oscillator monitor come from outside this clock
    pin_sync u_sync
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin_in({osc_fail, cmp_b_output, cmp_a_output}),
        .level(pin_level),
        .rise(pin_rise),
        .change(pin_change)
    );

    power_ctrl u_power
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .por_seen(por_seen),
        .brownout_reset(brownout_reset),
        .watchdog_reset(watchdog_reset),
        .ext_reset_pin(ext_reset_pin),
        .bus(pwr_bus.regs),
        .ulp_wake_en(ulp_wake_en),
        .sw_brownout_en(sw_brownout_en)
    );

    assign pwr_bus.wr = wr_power;
    assign pwr_bus.wdata = bus_wdata[7:0];

    // ==========================================================
    // flag set and clear; a set in the clearing cycle wins
    // writing one clears, the two serial bits are masked off
    assign sw_clear = wr_flag ? (bus_wdata[7:0] & `FLAG_SW_MASK) : 8'h00;

    always_comb
    begin
        next_flags = flags & ~sw_clear;
        // sets ignore every enable bit
        if (write_done_evt)
            next_flags.write_done_flag = 1'b1;
        if (conv_done_evt)
            next_flags.conversion_done_flag = 1'b1;
        if (pin_change[1])
            next_flags.cmp_b_change_flag = 1'b1;
        if (pin_change[0])
            next_flags.cmp_a_change_flag = 1'b1;
        if (pin_rise[2])
            next_flags.clk_fail_flag = 1'b1;
        if (timer_b_wrap_evt)
            next_flags.timer_b_wrap_flag = 1'b1;
        // serial bits are never stored here
        next_flags.rx_full_flag = 1'b0;
        next_flags.tx_empty_flag = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            flags <= `FLAG_RST;
        else
            flags <= next_flags;
    end

    // serial bits follow the unit's buffer state, read-only
    always_comb
    begin
        flag_view = flags;
        flag_view.rx_full_flag = rx_avail;
        flag_view.tx_empty_flag = tx_empty;
    end

    // ==========================================================
    // serial data path: the access itself tells the unit to clear
    assign rx_pop = rd_rxd;
    assign tx_push = wr_txd;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            tx_data <= 8'h00;
        else if (wr_txd)
            tx_data <= bus_wdata[7:0];
    end

    // ==========================================================
    // enable and control registers
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            periph_enable_reg <= `ENABLE_RST;
            ctrl <= `CTRL_RST;
        end
        else
        begin
            if (wr_enable)
                periph_enable_reg <= bus_wdata[7:0];
            if (wr_ctrl)
                ctrl <= bus_wdata[1:0];
        end
    end

    assign periph_irq_enable = ctrl[`CTRL_PERIPH_BIT];
    assign global_irq_enable = ctrl[`CTRL_GLOBAL_BIT];

    // ==========================================================
    // interrupt gating; a level, so a flag left pending when its
    // enable goes up fires at once, hence clear first
    assign periph_irq = periph_irq_enable
        && |(flag_view & periph_enable_reg);
    assign irq = periph_irq && global_irq_enable;

    // ==========================================================
    // read mux and registered read data
    assign read_mux =
        hit(bus_addr, `FLAG_OFS) ? byte_t'(flag_view) :
        hit(bus_addr, `ENABLE_OFS) ? periph_enable_reg :
        hit(bus_addr, `CTRL_OFS) ? {6'h00, ctrl} :
        hit(bus_addr, `POWER_OFS) ? pwr_bus.value :
        hit(bus_addr, `RXD_OFS) ? rx_data :
        8'h00; // transmit data and unmapped read as zero

    // data stands for the cycle after the strobe only
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            bus_rdata <= 32'h00000000;
        else if (bus_rd)
            bus_rdata <= {24'h000000, read_mux};
        else
            bus_rdata <= 32'h00000000;
    end

    // ==========================================================
    // checks
    set_ignores_en_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        timer_b_wrap_evt && !periph_enable_reg[0] && !periph_irq_enable
            |=> flags.timer_b_wrap_flag)
        else $error("flag did not set with its enable low");
    write_done_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        write_done_evt ##1 !sw_clear[7] [*3]
            |-> flags.write_done_flag)
        else $error("write-done flag lost before a clear");
    rx_read_data_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        rx_pop |=> bus_rdata[7:0] == $past(rx_data)
            && bus_rdata[31:8] == 24'h000000)
        else $error("receive data read did not return data");
    cmp_b_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $changed(pin_level[1]) |-> flags.cmp_b_change_flag)
        else $error("comparator B change missed");
    cmp_a_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $changed(pin_level[0]) |-> flags.cmp_a_change_flag)
        else $error("comparator A change missed");
    clk_fail_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(pin_level[2]) |-> flags.clk_fail_flag)
        else $error("oscillator failure not flagged");
    tx_write_data_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        tx_push |=> tx_data == $past(bus_wdata[7:0]))
        else $error("transmit data not latched");
    timer_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        sw_clear[0] && !timer_b_wrap_evt |=> !flags.timer_b_wrap_flag)
        else $error("timer flag not cleared by software");
    conv_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        conv_done_evt |=> flags.conversion_done_flag)
        else $error("conversion flag not set");
    periph_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        periph_irq |-> $past(ctrl[`CTRL_PERIPH_BIT]) || $past(wr_ctrl))
        else $error("peripheral interrupt without its enable");
    no_enable_quiet_a: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        periph_enable_reg == 8'h00 |-> !periph_irq)
        else $error("interrupt raised with every enable off");
    global_gate_a: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        irq |-> periph_irq && ctrl[`CTRL_GLOBAL_BIT])
        else $error("core interrupt without both enables");
    write_done_set_a: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        write_done_evt |=> flags.write_done_flag)
        else $error("write-done flag not set");
    set_beats_clear_a: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        timer_b_wrap_evt && sw_clear[0] |=> flags.timer_b_wrap_flag)
        else $error("clear beat a same-cycle timer event");
    clk_fail_hold_a: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        flags.clk_fail_flag && !sw_clear[2] |=> flags.clk_fail_flag)
        else $error("oscillator fail flag dropped without a clear");
    conv_hold_a: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        flags.conversion_done_flag && !sw_clear[6]
            |=> flags.conversion_done_flag)
        else $error("conversion flag dropped without a clear");
    rx_flag_read_a: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        bus_rd && hit(bus_addr, `FLAG_OFS)
            |=> bus_rdata[5] == $past(rx_avail))
        else $error("receive flag read does not follow the unit");
    tx_flag_read_a: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        bus_rd && hit(bus_addr, `FLAG_OFS)
            |=> bus_rdata[1] == $past(tx_empty))
        else $error("transmit flag read does not follow the unit");
    serial_not_stored_a: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        wr_flag |=> !flags.rx_full_flag && !flags.tx_empty_flag)
        else $error("serial flag bit stored by a write");
    rdata_idle_a: assert property (@(posedge sys_clk)
        disable iff (!rstn)
        !bus_rd |=> bus_rdata == 32'h00000000)
        else $error("read data stands without a read");
endmodule // peripheral_irq_flag_bank

/* File: hdl/irq_flag_cfg.svh */
// How it works
// - every flag sets on its event whatever its enable or global enable.
// - bit 7 sets when a memory write completes, holds until cleared.
// - bit 5 read-only, high while receive data waits, cleared by data read.
// - bit 4 sets on any change of comparator B output, holds until cleared.
// - bit 3 sets on any change of comparator A output, holds until cleared.
// - bit 2 sets when oscillator fails and clock falls back internally.
// - bit 1 read-only, high while transmit buffer empty, cleared by data write.
// - bit 0 sets on second timer rollover, reads zero otherwise, software clears.
// - power control register records power-on, brown-out, watchdog, external reset.
// - power control register holds writable wake-up and brown-out enable bits.
// - enable register has one bit per flag gating its interrupt.
// - peripheral interrupt enable must also be set to reach the core.
`ifndef IRQ_FLAG_CFG_SVH
`define IRQ_FLAG_CFG_SVH

// ==========================================================
// register offsets (byte addresses)
`define FLAG_OFS 8'h00
`define ENABLE_OFS 8'h04
`define CTRL_OFS 8'h08
`define POWER_OFS 8'h0C
`define RXD_OFS 8'h10
`define TXD_OFS 8'h14

// ==========================================================
// field positions
`define CTRL_PERIPH_BIT 0
`define CTRL_GLOBAL_BIT 1
`define PWR_BOR_BIT 0
`define PWR_POR_BIT 1
`define PWR_EXT_BIT 2
`define PWR_WDT_BIT 3
`define PWR_SBOREN_BIT 4
`define PWR_ULPWUE_BIT 5

// ==========================================================
// reset values and masks
`define FLAG_RST 8'h00
`define ENABLE_RST 8'h00
`define CTRL_RST 2'h0
`define PWR_RST 8'h13
`define FLAG_SW_MASK 8'hDD
`define PWR_RW_MASK 8'h30
`define SYNC_WIDTH 3

`endif

/* File: hdl/irq_flag_pkg.sv */
package irq_flag_pkg;

    // flag register layout, bit 7 first
    typedef struct packed
    {
        logic write_done_flag;
        logic conversion_done_flag;
        logic rx_full_flag;
        logic cmp_b_change_flag;
        logic cmp_a_change_flag;
        logic clk_fail_flag;
        logic tx_empty_flag;
        logic timer_b_wrap_flag;
    } flags_s;

    typedef logic [7:0] byte_t;
    typedef logic [31:0] word_t;

endpackage

/* File: hdl/pwr_bus_if.sv */
`timescale 1ns/1ps
// write path and read-back between register decode and power control
interface pwr_bus_if;
    logic wr;
    logic [7:0] wdata;
    logic [7:0] value;
    modport regs (output wr, output wdata, input value);
    modport unit (input wr, input wdata, output value);
endinterface // pwr_bus_if

/* File: hdl/pin_sync.sv */
`timescale 1ns/1ps
`include "irq_flag_cfg.svh"
module pin_sync
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [`SYNC_WIDTH-1:0] pin_in,
    output logic [`SYNC_WIDTH-1:0] level,
    output logic [`SYNC_WIDTH-1:0] rise,
    output logic [`SYNC_WIDTH-1:0] change
);
    // ==========================================================
    // three-stage synchroniser per pin
    genvar i;
    generate
        for (i = 0; i < `SYNC_WIDTH; i++)
        begin : g_pin
            logic s1, s2, s3, primed, lvl;
            logic agree;
            logic [1:0] fill;
            assign agree = (s2 == s3);
            // the chain fills for three edges and the level loads
            // silently before changes count, so a pin already high
            // at reset raises no false change
            assign change[i] = agree && primed && (s3 != lvl);
            assign rise[i] = change[i] && s3;
            assign level[i] = lvl;
            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    primed <= 1'b0;
                    lvl <= 1'b0;
                    fill <= 2'h0;
                end
                else
                begin
                    s1 <= pin_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    if (fill != 2'h3)
                        fill <= fill + 2'h1;
                    if (agree)
                    begin
                        if (fill == 2'h3)
                            primed <= 1'b1;
                        lvl <= s3;
                    end
                end
            end
        end
    endgenerate
endmodule // pin_sync

/* File: hdl/power_ctrl.sv */
`timescale 1ns/1ps
`include "irq_flag_cfg.svh"
module power_ctrl
    import irq_flag_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic por_seen,
    input wire logic brownout_reset,
    input wire logic watchdog_reset,
    input wire logic ext_reset_pin,
    pwr_bus_if.unit bus,
    output logic ulp_wake_en,
    output logic sw_brownout_en
);
    byte_t pwr;
    logic captured;

    // ==========================================================
    // cause levels are caught on the first edge after release,
    // never under the asynchronous reset itself
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pwr <= `PWR_RST;
            captured <= 1'b0;
        end
        else
        begin
            captured <= 1'b1;
            if (bus.wr)
            begin
                // controls store, status lows are set back by writing one
                pwr[`PWR_ULPWUE_BIT] <= bus.wdata[`PWR_ULPWUE_BIT];
                pwr[`PWR_SBOREN_BIT] <= bus.wdata[`PWR_SBOREN_BIT];
                pwr[`PWR_POR_BIT] <= pwr[`PWR_POR_BIT] | bus.wdata[`PWR_POR_BIT];
                pwr[`PWR_BOR_BIT] <= pwr[`PWR_BOR_BIT] | bus.wdata[`PWR_BOR_BIT];
                pwr[`PWR_WDT_BIT] <= pwr[`PWR_WDT_BIT] & ~bus.wdata[`PWR_WDT_BIT];
                pwr[`PWR_EXT_BIT] <= pwr[`PWR_EXT_BIT] & ~bus.wdata[`PWR_EXT_BIT];
            end
            if (!captured)
            begin
                // capture beats a same-cycle write
                pwr[`PWR_POR_BIT] <= ~por_seen;
                pwr[`PWR_BOR_BIT] <= ~brownout_reset;
                pwr[`PWR_WDT_BIT] <= watchdog_reset;
                pwr[`PWR_EXT_BIT] <= ext_reset_pin;
            end
        end
    end

    assign bus.value = pwr;
    assign ulp_wake_en = pwr[`PWR_ULPWUE_BIT];
    assign sw_brownout_en = pwr[`PWR_SBOREN_BIT];

    // ==========================================================
    // checks
    cause_capture_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        !captured |=> pwr[`PWR_POR_BIT] == !$past(por_seen)
            && pwr[`PWR_WDT_BIT] == $past(watchdog_reset))
        else $error("reset cause not captured after release");
    ctrl_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        bus.wr |=> ulp_wake_en == $past(bus.wdata[`PWR_ULPWUE_BIT])
            && sw_brownout_en == $past(bus.wdata[`PWR_SBOREN_BIT]))
        else $error("power control write not stored");
endmodule // power_ctrl

/* File: verif/serial_unit_model.sv */
`timescale 1ns/1ps
// ==========================================================
// serial unit stand-in: receive holding byte and transmit buffer
module serial_unit_model
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic rx_load,
    input wire logic [7:0] rx_byte,
    input wire logic tx_drain,
    input wire logic rx_pop,
    input wire logic tx_push,
    output logic rx_avail,
    output logic [7:0] rx_data,
    output logic tx_empty
);
    // receive side, byte inverted on each take, so stale data after one take never matches
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_avail <= 1'b0;
            rx_data <= 8'h00;
        end
        else if (rx_load)
        begin
            rx_avail <= 1'b1;
            rx_data <= rx_byte;
        end
        else if (rx_pop)
        begin
            rx_avail <= 1'b0;
            rx_data <= ~rx_data;
        end
    end

    // transmit side, empty until software pushes a byte
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            tx_empty <= 1'b1;
        else if (tx_push)
            tx_empty <= 1'b0;
        else if (tx_drain)
            tx_empty <= 1'b1;
    end
endmodule // serial_unit_model

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import irq_flag_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    word_t bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    word_t bus_rdata;
    logic [2:0] evt = 3'h0;
    logic cmp_a = 1'b0;
    logic cmp_b = 1'b0;
    logic osc_fail = 1'b0;
    logic rx_load = 1'b0;
    logic tx_drain = 1'b0;
    logic rx_avail, tx_empty, rx_pop, tx_push, periph_irq, irq;
    logic ulp_wake_en, sw_brownout_en;
    byte_t rx_data, tx_data;
    int errors = 0;
    int n_checks = 0;

    // 10 MHz clock
    always #50 sys_clk = ~sys_clk;

    peripheral_irq_flag_bank dut_u
    (
        .sys_clk(sys_clk), .rstn(rstn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .write_done_evt(evt[2]),
        .conv_done_evt(evt[1]), .timer_b_wrap_evt(evt[0]),
        .rx_avail(rx_avail), .rx_data(rx_data), .tx_empty(tx_empty),
        .cmp_a_output(cmp_a), .cmp_b_output(cmp_b), .osc_fail(osc_fail),
        .por_seen(1'b1), .brownout_reset(1'b0), .watchdog_reset(1'b0),
        .ext_reset_pin(1'b0), .rx_pop(rx_pop), .tx_push(tx_push),
        .tx_data(tx_data), .periph_irq(periph_irq), .irq(irq),
        .ulp_wake_en(ulp_wake_en), .sw_brownout_en(sw_brownout_en)
    );

    serial_unit_model unit_u
    (
        .sys_clk(sys_clk), .rstn(rstn), .rx_load(rx_load),
        .rx_byte(8'hA5), .tx_drain(tx_drain), .rx_pop(rx_pop),
        .tx_push(tx_push), .rx_avail(rx_avail), .rx_data(rx_data),
        .tx_empty(tx_empty)
    );

    // ==========================================================
    // checking and bus tasks
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= {24'h000000, d};
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe, so look mid-cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(negedge sys_clk);
        chk($sformatf("reg %h", a), {24'h000000, e}, bus_rdata);
    endtask

    task automatic pulse(input logic [2:0] m);
        @(posedge sys_clk);
        evt <= m;
        @(posedge sys_clk);
        evt <= 3'h0;
    endtask

    task automatic chk_irq(input logic p, input logic i);
        @(negedge sys_clk);
        chk("periph_irq", {31'h0, p}, {31'h0, periph_irq});
        chk("irq", {31'h0, i}, {31'h0, irq});
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ==========================================================
    // watchdog, far beyond the hundred-odd cycles the tests need
    initial
    begin
        #(5000 * 100);
        errors++;
        conclude();
    end

    // ==========================================================
    // test sequence
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(8'h00, 8'h02);
        rd(8'h0C, 8'h11);
        chk("sw_brownout_en", 32'h1, {31'h0, sw_brownout_en});
        $display("test reset done");
        // events with every enable off still set their flags
        pulse(3'h7);
        chk_irq(1'b0, 1'b0);
        rd(8'h00, 8'hC3);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h02);
        pulse(3'h4);
        pulse(3'h1);
        rd(8'h00, 8'h83);
        wr(8'h00, 8'h81);
        rd(8'h00, 8'h02);
        $display("test events done");
        // synchronised pin changes, both directions on comparator A, rising on B
        cmp_a <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(8'h00, 8'h0A);
        wr(8'h00, 8'h08);
        cmp_a <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(8'h00, 8'h0A);
        cmp_b <= 1'b1;
        osc_fail <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(8'h00, 8'h1E);
        wr(8'h00, 8'h1C);
        rd(8'h00, 8'h02);
        $display("test pins done");
        // serial flags follow the unit and ignore software clears
        @(posedge sys_clk);
        rx_load <= 1'b1;
        @(posedge sys_clk);
        rx_load <= 1'b0;
        wr(8'h00, 8'h22);
        rd(8'h00, 8'h22);
        rd(8'h10, 8'hA5);
        rd(8'h00, 8'h02);
        wr(8'h14, 8'h3C);
        @(negedge sys_clk);
        chk("tx_data", 32'h3C, {24'h0, tx_data});
        rd(8'h00, 8'h00);
        $display("test serial done");
        // gating: flag cleared before its enable goes on
        pulse(3'h1);
        wr(8'h00, 8'h01);
        wr(8'h04, 8'h01);
        pulse(3'h1);
        chk_irq(1'b0, 1'b0);
        wr(8'h08, 8'h01);
        chk_irq(1'b1, 1'b0);
        wr(8'h08, 8'h03);
        chk_irq(1'b1, 1'b1);
        wr(8'h04, 8'h00);
        chk_irq(1'b0, 1'b0);
        wr(8'h04, 8'h01);
        wr(8'h00, 8'h01);
        chk_irq(1'b0, 1'b0);
        $display("test gating done");
        // power controls and an unmapped place
        wr(8'h0C, 8'h20);
        rd(8'h0C, 8'h21);
        chk("ulp_wake_en", 32'h1, {31'h0, ulp_wake_en});
        chk("sw_brownout_en", 32'h0, {31'h0, sw_brownout_en});
        wr(8'h40, 8'hFF);
        rd(8'h40, 8'h00);
        rd(8'h04, 8'h01);
        $display("test power done");
        conclude();
    end
endmodule // tb_top
